/* hdl/bas_alu.sv */
// byte alu slice with accumulator, flags and file registers
//
// Design decisions made here: strobed register access and the register offsets.
`timescale 1ns/10ps
`include "bas_cfg.svh"
module bas_alu
	import bas_pkg::*;
#(
	parameter int DEPTH = `BAS_FILE_DEPTH
) (
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	input  wire logic [6:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output      logic [7:0]  reg_rdata,
	output      logic [7:0]  acc,
	output      logic        carry_flag,
	output      logic        digit_carry_flag,
	output      logic        zero_flag,
	output      logic        busy
);
	bas_file_if #(.AW(`BAS_ADDR_W), .DW(`BAS_DATA_W)) fp ();
	bas_file_mem #(.DEPTH(DEPTH)) u_mem (.clk_sys(clk_sys), .fp(fp));

	// refused at elaboration: the address field reaches 128 entries only
	if (DEPTH < 1 || DEPTH > 128) begin : g_depth_check
		$error("file depth must be 1..128");
	end

	bas_state_e state_reg, state_next;
	logic [7:0] acc_reg, acc_next;
	logic [2:0] flags_reg, flags_next;
	logic [3:0] op_reg;
	logic [7:0] lit_reg;
	logic [6:0] faddr_reg;
	logic [7:0] rdata_reg;
	logic [7:0] opnd_reg;

	wire wr_acc   = reg_wr && reg_addr == `BAS_REG_ACC;
	wire wr_op    = reg_wr && reg_addr == `BAS_REG_OP;
	wire wr_lit   = reg_wr && reg_addr == `BAS_REG_LIT;
	wire wr_faddr = reg_wr && reg_addr == `BAS_REG_FADDR;
	wire wr_go    = reg_wr && reg_addr == `BAS_REG_GO && state_reg == BAS_ST_IDLE;
	wire [2:0] op_sel = op_reg[2:0];
	wire dest_file    = op_reg[`BAS_OP_DEST];
	// literal xor needs no file read
	wire go_lit = wr_go && op_sel == BAS_OP_XOR_LIT;
	wire go_reg = wr_go && !go_lit;

	wire [8:0] sub_full = {1'b0, opnd_reg} - {1'b0, acc_reg};
	wire [4:0] sub_low  = {1'b0, opnd_reg[3:0]} - {1'b0, acc_reg[3:0]};
	wire [7:0] xor_res  = acc_reg ^ opnd_reg;
	wire [7:0] swap_res = {opnd_reg[3:0], opnd_reg[7:4]};
	wire [7:0] lit_res  = acc_reg ^ lit_reg;
	logic [7:0] alu_res;
	always_comb begin
		unique case (op_sel)
			BAS_OP_SUB_REG:  alu_res = sub_full[7:0];
			BAS_OP_XOR_REG:  alu_res = xor_res;
			BAS_OP_SWAP_REG: alu_res = swap_res;
			default:         alu_res = xor_res;
		endcase
	end

	wire exec = state_reg == BAS_ST_WRITE;
	wire to_file = exec && dest_file;
	wire to_acc  = exec && !dest_file;
	assign fp.we    = to_file;
	assign fp.addr  = faddr_reg;
	assign fp.wdata = alu_res;

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			BAS_ST_IDLE:  if (go_reg) state_next = BAS_ST_READ;
			BAS_ST_READ:  state_next = BAS_ST_WRITE;
			BAS_ST_WRITE: state_next = BAS_ST_IDLE;
			default:      state_next = BAS_ST_IDLE;
		endcase
	end

	always_comb begin
		acc_next   = acc_reg;
		flags_next = flags_reg;
		if (wr_acc)
			acc_next = reg_wdata;
		if (go_lit) begin
			acc_next = lit_res;
			flags_next[`BAS_STAT_Z] = lit_res == 8'h00;
		end
		if (to_acc)
			acc_next = alu_res;
		if (exec) begin
			if (op_sel != BAS_OP_SWAP_REG)
				flags_next[`BAS_STAT_Z] = alu_res == 8'h00;
			if (op_sel == BAS_OP_SUB_REG) begin
				flags_next[`BAS_STAT_C]  = !sub_full[8];
				flags_next[`BAS_STAT_DC] = !sub_low[4];
			end
		end
		if (reg_wr && reg_addr == `BAS_REG_STAT)
			flags_next = reg_wdata[2:0];
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= BAS_ST_IDLE;
			acc_reg   <= `BAS_ACC_RST;
			flags_reg <= 3'h0;
			op_reg    <= 4'h0;
			lit_reg   <= 8'h00;
			faddr_reg <= 7'h00;
		end else begin
			state_reg <= state_next;
			acc_reg   <= acc_next;
			flags_reg <= flags_next;
			if (wr_op)
				op_reg <= reg_wdata[3:0];
			if (wr_lit)
				lit_reg <= reg_wdata;
			if (wr_faddr && state_reg == BAS_ST_IDLE)
				faddr_reg <= reg_wdata[6:0];
		end
	end

	// memory data valid in the read state
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			opnd_reg <= 8'h00;
		else if (state_reg == BAS_ST_READ)
			opnd_reg <= fp.rdata;
	end

	logic [7:0] rd_mux;
	always_comb begin
		unique case (reg_addr)
			`BAS_REG_ACC:   rd_mux = acc_reg;
			`BAS_REG_STAT:  rd_mux = {4'h0, busy, flags_reg};
			`BAS_REG_OP:    rd_mux = {4'h0, op_reg};
			`BAS_REG_LIT:   rd_mux = lit_reg;
			`BAS_REG_FADDR: rd_mux = {1'b0, faddr_reg};
			default:        rd_mux = 8'h00;
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			rdata_reg <= 8'h00;
		else
			rdata_reg <= reg_rd ? rd_mux : 8'h00;
	end

	assign reg_rdata        = rdata_reg;
	assign acc              = acc_reg;
	assign carry_flag       = flags_reg[`BAS_STAT_C];
	assign digit_carry_flag = flags_reg[`BAS_STAT_DC];
	assign zero_flag        = flags_reg[`BAS_STAT_Z];
	assign busy             = state_reg != BAS_ST_IDLE;
endmodule // bas_alu

/* hdl/bas_cfg.svh */
// constants for the byte alu slice
`ifndef BAS_CFG_SVH
`define BAS_CFG_SVH
`define BAS_DATA_W      8
`define BAS_ADDR_W      7
`define BAS_ACC_RST     8'h00
`define BAS_FILE_DEPTH  128
`define BAS_REG_ACC     7'h00
`define BAS_REG_STAT    7'h01
`define BAS_REG_OP      7'h02
`define BAS_REG_LIT     7'h03
`define BAS_REG_FADDR   7'h04
`define BAS_REG_GO      7'h05
`define BAS_STAT_C      0
`define BAS_STAT_DC     1
`define BAS_STAT_Z      2
`define BAS_STAT_BUSY   3
`define BAS_OP_DEST     3
`endif

/* hdl/bas_file_if.sv */
// file register port between core and memory
`timescale 1ns/10ps
interface bas_file_if #(parameter int AW = 7, parameter int DW = 8);
	logic          we;
	logic [AW-1:0] addr;
	logic [DW-1:0] wdata;
	logic [DW-1:0] rdata;
	modport core (output we, output addr, output wdata, input rdata);
	modport mem  (input we, input addr, input wdata, output rdata);
endinterface

/* hdl/bas_file_mem.sv */
// file register memory, registered read
`timescale 1ns/10ps
module bas_file_mem #(
	parameter int DEPTH = 128
) (
	input wire logic clk_sys,
	bas_file_if.mem  fp
);
	// power-up content zero: the host cannot load the file directly, so it must start known
	logic [7:0] mem_reg [DEPTH] = '{default: 8'h00};
	logic [7:0] rdata_reg;
	initial begin
		if (DEPTH > (1 << $bits(fp.addr)))
			$error("depth exceeds address range");
	end
	always_ff @(posedge clk_sys) begin
		if (fp.we)
			mem_reg[fp.addr] <= fp.wdata;
		rdata_reg <= mem_reg[fp.addr];
	end
	assign fp.rdata = rdata_reg;
endmodule // bas_file_mem

/* hdl/bas_pkg.sv */
// types for the byte alu slice
package bas_pkg;
	typedef enum logic [2:0] {
		BAS_OP_SUB_REG  = 3'h0,
		BAS_OP_XOR_LIT  = 3'h1,
		BAS_OP_XOR_REG  = 3'h2,
		BAS_OP_SWAP_REG = 3'h3
	} bas_op_e;
	typedef enum logic [2:0] {
		BAS_ST_IDLE  = 3'b001,
		BAS_ST_READ  = 3'b010,
		BAS_ST_WRITE = 3'b100
	} bas_state_e;
endpackage

/* tb/bas_alu_checker.sv */
// port assertions for the byte alu slice
`timescale 1ns/10ps
module bas_alu_checker (
	input wire logic       clk_sys,
	input wire logic       rst_n,
	input wire logic [6:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic [7:0] acc,
	input wire logic       carry_flag,
	input wire logic       digit_carry_flag,
	input wire logic       zero_flag,
	input wire logic       busy
);
	logic [3:0] op_reg;
	logic [7:0] lit_reg;
	wire        go     = reg_wr && reg_addr == 7'h05 && !busy;
	wire        lit_go = go && op_reg[2:0] == 3'h1;
	wire        reg_go = go && op_reg[2:0] != 3'h1;
	wire [2:0]  flags  = {carry_flag, digit_carry_flag, zero_flag};
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			op_reg  <= 4'h0;
			lit_reg <= 8'h00;
		end else if (reg_wr && reg_addr == 7'h02) begin
			op_reg <= reg_wdata[3:0];
		end else if (reg_wr && reg_addr == 7'h03) begin
			lit_reg <= reg_wdata;
		end
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	chk_xor_acc: assert property (
		lit_go |=> acc == $past(acc ^ lit_reg)) else $error("xor literal result wrong");
	chk_xor_zero: assert property (
		lit_go |=> zero_flag == (acc == 8'h00)) else $error("xor zero flag wrong");
	chk_xor_carry: assert property (
		lit_go |=> $stable(carry_flag) && $stable(digit_carry_flag)) else $error("xor moved carry");
	chk_busy_span: assert property (
		reg_go |=> busy [*2] ##1 !busy) else $error("register op length wrong");
	chk_busy_cause: assert property (
		$rose(busy) |-> $past(reg_go)) else $error("busy without start");
	chk_dest_file: assert property (
		reg_go && op_reg[3] |-> ##3 acc == $past(acc, 3)) else $error("file dest hit acc");
	chk_swap_flags: assert property (
		go && op_reg[2:0] == 3'h3 |-> ##3 flags == $past(flags, 3)) else $error("swap moved flags");
	chk_sub_flags: assert property (
		reg_go && op_reg == 4'h0 |-> ##3 carry_flag == (8'(acc + $past(acc, 3)) >= $past(acc, 3))
			&& digit_carry_flag == (4'(acc[3:0] + $past(acc[3:0], 3)) >= $past(acc[3:0], 3))
			&& zero_flag == (acc == 8'h00)) else $error("subtract flags wrong");
	chk_xor_reg_z: assert property (
		reg_go && op_reg == 4'h2 |-> ##3 zero_flag == (acc == 8'h00)
			&& carry_flag == $past(carry_flag, 3)) else $error("xor register flags wrong");
endmodule // bas_alu_checker

/* tb/bas_alu_test.sv */
// self-checking bench for the byte alu slice
`timescale 1ns/10ps
module bas_alu_test;
	logic       clk_sys = 1'b0;
	logic       rst_n = 1'b0;
	logic [6:0] reg_addr = 7'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic       reg_wr = 1'b0;
	logic       reg_rd = 1'b0;
	logic [7:0] reg_rdata, acc;
	logic       carry_flag, digit_carry_flag, zero_flag, busy;
	wire  [7:0] flags8 = {5'h00, carry_flag, digit_carry_flag, zero_flag};
	int         errors = 0;
	int         n_tests = 0;
	bas_alu bas_alu_i (.clk_sys, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .acc, .carry_flag, .digit_carry_flag, .zero_flag, .busy);
	initial forever #25 clk_sys = ~clk_sys;
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic give_verdict;
		$display("errors %0d in %0d checks", errors, n_tests);
		if (errors == 0 && n_tests > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [6:0] a, input logic [7:0] exp);
		@(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 check(reg_rdata, exp);
	endtask
	// dest bit set on purpose: literal result still lands in acc
	task automatic t_xor_lit;
		wr(7'h01, 8'h03);
		wr(7'h00, 8'h35);
		wr(7'h03, 8'hff);
		wr(7'h02, 8'h09);
		wr(7'h05, 8'h00);
		@(posedge clk_sys);
		#1 check(acc, 8'hca);
		check(flags8, 8'h06);
		wr(7'h03, 8'hca);
		wr(7'h05, 8'h00);
		@(posedge clk_sys);
		#1 check(acc, 8'h00);
		check(flags8, 8'h07);
	endtask
	// file 0x10 starts at zero, so each step follows from the one before
	task automatic t_reg_op(input logic [3:0] op, input logic [7:0] a, input logic [7:0] exp_acc,
		input logic [2:0] exp_fl);
		int i;
		wr(7'h00, a);
		wr(7'h01, 8'h03);
		wr(7'h02, {4'h0, op});
		wr(7'h04, 8'h10);
		wr(7'h05, 8'h00);
		#1;
		for (i = 0; i < 8 && busy !== 1'b0; i++) begin
			@(posedge clk_sys);
			#1;
		end
		// a hang counts twice, here and in the step count check; the rest of the run stays bounded
		if (i == 8)
			errors++;
		check(8'(i), 8'h02);
		check(acc, exp_acc);
		check(flags8, {5'h00, exp_fl});
		rd(7'h00, exp_acc);
		rd(7'h01, {5'h00, exp_fl[0], exp_fl[1], exp_fl[2]});
	endtask
	// reset in the middle of a register operation
	task automatic t_reset_mid;
		wr(7'h00, 8'h77);
		wr(7'h05, 8'h00);
		@(posedge clk_sys);
		rst_n <= 1'b0;
		@(posedge clk_sys);
		#1 check({7'h00, busy}, 8'h00);
		check(acc, 8'h00);
		check(flags8, 8'h00);
		@(posedge clk_sys);
		rst_n <= 1'b1;
	endtask
	initial begin
		repeat (20) @(posedge clk_sys);
		check(acc, 8'h00);
		rst_n <= 1'b1;
		t_xor_lit;
		t_reg_op(4'h8, 8'h5a, 8'h5a, 3'h0);
		t_reg_op(4'hb, 8'h5a, 8'h5a, 3'h6);
		t_reg_op(4'ha, 8'h0f, 8'h0f, 3'h6);
		t_reg_op(4'h3, 8'h33, 8'h56, 3'h6);
		t_reg_op(4'h0, 8'h26, 8'h3f, 3'h4);
		t_reg_op(4'h2, 8'h65, 8'h00, 3'h7);
		t_reg_op(4'h5, 8'h00, 8'h65, 3'h6);
		rd(7'h04, 8'h10);
		rd(7'h7f, 8'h00);
		t_reset_mid;
		t_xor_lit;
		give_verdict;
	end
endmodule // bas_alu_test
bind bas_alu bas_alu_checker bas_alu_checker_i (.clk_sys, .rst_n, .reg_addr, .reg_wdata,
	.reg_wr, .reg_rd, .reg_rdata, .acc, .carry_flag, .digit_carry_flag, .zero_flag, .busy);
